// ==== rtl/bpc_bank.sv ====
// bpc_bank: boost and protection configuration bank with fault status,
// interrupt, external boost clock fallback and spread spectrum dither.
// assumes classic wishbone single cycles, events as one-cycle pulses and
// a sync pin already synchronous to clk.
//
// Functional notes
// [RULE1] bit 4 picks line or frame reference
// [RULE2] bits 3:0 hold internal dimming rate code
// [RULE3] inhibit bit hides boost overvoltage reporting
// [RULE4] inhibit bit stops overcurrent recovery entry only
// [RULE5] inhibit bit stops supply overvolt recovery only
// [RULE6] inhibit bit stops supply undervolt recovery only
// [RULE7] undervolt threshold code: off, 3, 5, 8 V
// [RULE8] overvolt threshold code: off, 7, 11, 22.5 V
// [RULE9] ramp delay of 35 % when enabled
// [RULE10] bit 4 picks internal or external boost clock
// [RULE11] external clock gone 1.52 periods: use internal
// [RULE12] current limit 2 A to 9 A
// [RULE13] gate driver from charge pump or rail
// [RULE14] spread spectrum +-3 % at 1.875 kHz
// [RULE15] ramp peak from four by four table
// [RULE16] internal switching rate table 100..2200 kHz
// [RULE17] fallback switching rate table 100..2500 kHz
// [RULE18] reserved bits read zero, writes ignored
`timescale 1ns/1ns
module bpc_bank #(
    parameter int SS_MOD_CYCLES = bpc_pkg::SS_MOD_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // fault events and sync pin
    input bpc_pkg::bpc_evt_t evt_i,
    input wire logic sync_in,
    // decoded settings and fault outputs
    output bpc_pkg::bpc_cfg_t cfg_o,
    output logic fault_o,
    output logic recovery_o,
    output logic irq_o
);
    localparam int SS_STEP = SS_MOD_CYCLES / (4 * bpc_pkg::SS_SPAN_PCT);

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    function automatic logic [11:0] int_khz(input logic [2:0] c);
        unique case (c)
            3'h0: int_khz = 12'd100;
            3'h1: int_khz = 12'd200;
            3'h2: int_khz = 12'd303;
            3'h3: int_khz = 12'd400;
            3'h4: int_khz = 12'd629;
            3'h5: int_khz = 12'd1100;
            3'h6: int_khz = 12'd1100;
            3'h7: int_khz = 12'd2200;
        endcase
    endfunction : int_khz

    function automatic logic [11:0] fb_khz(input logic [2:0] c);
        unique case (c)
            3'h0: fb_khz = 12'd100;
            3'h1: fb_khz = 12'd200;
            3'h2: fb_khz = 12'd303;
            3'h3: fb_khz = 12'd400;
            3'h4: fb_khz = 12'd625;
            3'h5: fb_khz = 12'd1111;
            3'h6: fb_khz = 12'd1111;
            3'h7: fb_khz = 12'd2500;
        endcase
    endfunction : fb_khz

    // peak in tenths; two cells with no figure take neighbours' trend
    function automatic logic [10:0] ramp_x10(input logic [1:0] r,
                                             input logic [1:0] ind);
        unique case ({r, ind})
            4'h0: ramp_x10 = 11'd1300;
            4'h1: ramp_x10 = 11'd650;
            4'h2: ramp_x10 = 11'd340;
            4'h3: ramp_x10 = 11'd290;
            4'h4: ramp_x10 = 11'd880;
            4'h5: ramp_x10 = 11'd430;
            4'h6: ramp_x10 = 11'd230;
            4'h7: ramp_x10 = 11'd200;
            4'h8: ramp_x10 = 11'd560;
            4'h9: ramp_x10 = 11'd280;
            4'ha: ramp_x10 = 11'd150;
            4'hb: ramp_x10 = 11'd130;
            4'hc: ramp_x10 = 11'd370;
            4'hd: ramp_x10 = 11'd180;
            4'he: ramp_x10 = 11'd100;
            4'hf: ramp_x10 = 11'd85;
        endcase
    endfunction : ramp_x10

    function automatic logic [7:0] uv_dv(input logic [1:0] c);
        unique case (c)
            2'h0: uv_dv = 8'd0;
            2'h1: uv_dv = 8'd30;
            2'h2: uv_dv = 8'd50;
            2'h3: uv_dv = 8'd80;
        endcase
    endfunction : uv_dv

    function automatic logic [7:0] ov_dv(input logic [1:0] c);
        unique case (c)
            2'h0: ov_dv = 8'd0;
            2'h1: ov_dv = 8'd70;
            2'h2: ov_dv = 8'd110;
            2'h3: ov_dv = 8'd225;
        endcase
    endfunction : ov_dv

    logic [7:0] rate_q;
    logic [7:0] prot_q;
    logic [7:0] drive_q;
    logic [7:0] clkcfg_q;
    logic [3:0] stat_q;
    logic [3:0] stat_d;
    logic [3:0] mask_q;
    logic [3:0] evt_set;
    logic ack_q;
    logic [31:0] dat_q;
    logic acc;
    logic wr_fire;
    logic addr_ok;
    logic [7:0] idx;
    logic [7:0] wbyte;
    logic [7:0] rd_byte;
    logic fault_q;
    logic irq_q;
    logic rec_q;
    logic uv_on;
    logic ov_on;
    logic rec_d;
    bpc_pkg::bpc_clk_state_t clk_state_q;
    logic sync_prev_q;
    logic sync_edge;
    logic [15:0] cnt_q;
    logic [15:0] period_q;
    logic absent;
    logic ext_sel;
    logic [15:0] ss_cnt_q;
    logic signed [2:0] ss_pct_q;
    logic ss_up_q;
    bpc_pkg::bpc_cfg_t cfg_d;
    bpc_pkg::bpc_cfg_t cfg_q;

    // bus decode; ack comes one cycle after the request is seen
    assign acc = wb_cyc_i & wb_stb_i;
    assign idx = wb_adr_i[9:2];
    assign addr_ok = (wb_adr_i[31:10] == 22'h0) && (wb_adr_i[1:0] == 2'h0);
    // a write lands on the edge where the master sees ack high
    assign wr_fire = acc & wb_we_i & ack_q & wb_sel_i[0] & addr_ok;
    assign wbyte = wb_dat_i[7:0];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= acc & ~ack_q;
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        if (addr_ok) begin
            unique case (idx)
                bpc_pkg::IDX_RATE: rd_byte = rate_q;
                bpc_pkg::IDX_PROT: rd_byte = prot_q;
                bpc_pkg::IDX_DRIVE: rd_byte = drive_q;
                bpc_pkg::IDX_CLOCK: rd_byte = clkcfg_q;
                bpc_pkg::IDX_STAT: rd_byte = {4'h0, stat_q};
                bpc_pkg::IDX_MASK: rd_byte = {4'h0, mask_q};
                bpc_pkg::IDX_CLKST: rd_byte = {6'h0, ~absent,
                    clk_state_q == bpc_pkg::BPC_CLK_FALLBACK};
                default: rd_byte = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dat_q <= 32'h0;
        end else if (acc & ~ack_q) begin
            dat_q <= {24'h0, rd_byte};
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // configuration registers; reserved bits never store
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rate_q <= bpc_pkg::RATE_RST;
            prot_q <= bpc_pkg::PROT_RST;
            drive_q <= bpc_pkg::DRV_RST;
            clkcfg_q <= bpc_pkg::CLK_RST;
            mask_q <= bpc_pkg::EVT_RST;
        end else if (wr_fire) begin
            if (idx == bpc_pkg::IDX_RATE)
                rate_q <= wbyte & bpc_pkg::RATE_WMASK; // [RULE18]
            if (idx == bpc_pkg::IDX_PROT)
                prot_q <= wbyte & bpc_pkg::PROT_WMASK;
            if (idx == bpc_pkg::IDX_DRIVE)
                drive_q <= wbyte & bpc_pkg::DRV_WMASK; // [RULE18]
            if (idx == bpc_pkg::IDX_CLOCK)
                clkcfg_q <= wbyte & bpc_pkg::CLK_WMASK;
            if (idx == bpc_pkg::IDX_MASK)
                mask_q <= wbyte[3:0];
        end
    end

    // fault events; a zero threshold code turns detection off
    assign uv_on = prot_q[bpc_pkg::PROT_UV_LSB +: 2] != 2'h0; // [RULE7]
    assign ov_on = prot_q[bpc_pkg::PROT_OV_LSB +: 2] != 2'h0; // [RULE8]

    always_comb begin
        evt_set = 4'h0;
        evt_set[bpc_pkg::EVT_BOVP] = evt_i.boost_ovp &
            ~prot_q[bpc_pkg::PROT_BOVP_BIT]; // [RULE3]
        evt_set[bpc_pkg::EVT_BOCP] = evt_i.boost_ocp; // [RULE4]
        evt_set[bpc_pkg::EVT_SOVP] = evt_i.supply_ovp & ov_on; // [RULE5]
        evt_set[bpc_pkg::EVT_SUV] = evt_i.supply_uv & uv_on; // [RULE6]
    end

    // set wins over a same-cycle write-one-to-clear
    always_comb begin
        stat_d = stat_q;
        if (wr_fire && idx == bpc_pkg::IDX_STAT)
            stat_d = stat_q & ~wbyte[3:0];
        stat_d = stat_d | evt_set;
    end

    always_comb begin
        rec_d = (evt_i.boost_ocp & ~prot_q[bpc_pkg::PROT_BOCP_BIT]) // [RULE4]
            | (evt_i.supply_ovp & ov_on
               & ~prot_q[bpc_pkg::PROT_SOVP_BIT]) // [RULE5]
            | (evt_i.supply_uv & uv_on
               & ~prot_q[bpc_pkg::PROT_SUV_BIT]); // [RULE6]
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_q <= bpc_pkg::EVT_RST;
            fault_q <= 1'b0;
            irq_q <= 1'b0;
            rec_q <= 1'b0;
        end else begin
            stat_q <= stat_d;
            fault_q <= |stat_d; // [RULE3]
            irq_q <= |(stat_d & mask_q);
            rec_q <= rec_d;
        end
    end

    assign fault_o = fault_q;
    assign irq_o = irq_q;
    assign recovery_o = rec_q;

    // external clock watch: measure the sync period in clk cycles
    assign ext_sel = drive_q[bpc_pkg::DRV_EXT_BIT];
    assign sync_edge = sync_in & ~sync_prev_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_prev_q <= 1'b0;
            cnt_q <= 16'h0;
            period_q <= 16'h0;
        end else begin
            sync_prev_q <= sync_in;
            if (sync_edge) begin
                cnt_q <= 16'h0;
                period_q <= (cnt_q == 16'hffff) ? cnt_q : cnt_q + 16'h1;
            end else if (cnt_q != 16'hffff) begin
                cnt_q <= cnt_q + 16'h1;
            end
        end
    end

    // without a measured period only a saturated count means gone
    always_comb begin
        if (period_q == 16'h0)
            absent = cnt_q == 16'hffff;
        else
            absent = ({8'h0, cnt_q} * bpc_pkg::ABSENT_DEN) >
                     ({8'h0, period_q} * bpc_pkg::ABSENT_NUM); // [RULE11]
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_state_q <= bpc_pkg::BPC_CLK_INT;
        end else begin
            unique case (clk_state_q)
                bpc_pkg::BPC_CLK_INT: begin
                    if (ext_sel)
                        clk_state_q <= bpc_pkg::BPC_CLK_EXT; // [RULE10]
                end
                bpc_pkg::BPC_CLK_EXT: begin
                    if (!ext_sel)
                        clk_state_q <= bpc_pkg::BPC_CLK_INT;
                    else if (absent)
                        clk_state_q <= bpc_pkg::BPC_CLK_FALLBACK; // [RULE11]
                end
                bpc_pkg::BPC_CLK_FALLBACK: begin
                    if (!ext_sel)
                        clk_state_q <= bpc_pkg::BPC_CLK_INT;
                    else if (sync_edge)
                        clk_state_q <= bpc_pkg::BPC_CLK_EXT;
                end
            endcase
        end
    end

    // triangle dither, one percent step per twelfth of the modulation period
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ss_cnt_q <= 16'h0;
            ss_pct_q <= 3'sd0;
            ss_up_q <= 1'b1;
        end else if (!clkcfg_q[bpc_pkg::CLK_SS_BIT]) begin
            ss_cnt_q <= 16'h0;
            ss_pct_q <= 3'sd0;
            ss_up_q <= 1'b1;
        end else if (ss_cnt_q == 16'(SS_STEP - 1)) begin // [RULE14]
            ss_cnt_q <= 16'h0;
            if (ss_up_q) begin
                ss_pct_q <= ss_pct_q + 3'sd1;
                if (ss_pct_q == 3'sd2)
                    ss_up_q <= 1'b0;
            end else begin
                ss_pct_q <= ss_pct_q - 3'sd1;
                if (ss_pct_q == -3'sd2)
                    ss_up_q <= 1'b1;
            end
        end else begin
            ss_cnt_q <= ss_cnt_q + 16'h1;
        end
    end

    // decoded settings, registered so outputs come from flops
    always_comb begin
        cfg_d.frame_rate_ref = rate_q[bpc_pkg::RATE_REF_BIT]; // [RULE1]
        cfg_d.dimming_rate_code =
            rate_q[bpc_pkg::RATE_CODE_LSB +: 4]; // [RULE2]
        cfg_d.undervolt_dv = uv_dv(prot_q[bpc_pkg::PROT_UV_LSB +: 2]);
        cfg_d.overvolt_dv = ov_dv(prot_q[bpc_pkg::PROT_OV_LSB +: 2]);
        cfg_d.ramp_delay_pct = drive_q[bpc_pkg::DRV_DELAY_BIT] ?
            bpc_pkg::RAMP_DELAY_PCT : 6'h0; // [RULE9]
        cfg_d.current_limit_a = bpc_pkg::IMAX_BASE_A +
            {1'b0, drive_q[bpc_pkg::DRV_IMAX_LSB +: 3]}; // [RULE12]
        cfg_d.gate_drive_supply_select =
            drive_q[bpc_pkg::DRV_GD_BIT]; // [RULE13]
        cfg_d.ramp_peak_x10 = ramp_x10(
            clkcfg_q[bpc_pkg::CLK_RAMP_LSB +: 2],
            clkcfg_q[bpc_pkg::CLK_IND_LSB +: 2]); // [RULE15]
        unique case (clk_state_q)
            bpc_pkg::BPC_CLK_INT: cfg_d.switching_khz =
                int_khz(clkcfg_q[bpc_pkg::CLK_FREQ_LSB +: 3]); // [RULE16]
            bpc_pkg::BPC_CLK_FALLBACK: cfg_d.switching_khz =
                fb_khz(clkcfg_q[bpc_pkg::CLK_FREQ_LSB +: 3]); // [RULE17]
            bpc_pkg::BPC_CLK_EXT: cfg_d.switching_khz = 12'h0;
            default: cfg_d.switching_khz = 12'h0;
        endcase
        cfg_d.spread_pct = ss_pct_q; // [RULE14]
        cfg_d.use_ext_clk = clk_state_q == bpc_pkg::BPC_CLK_EXT;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= '0;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    assign cfg_o = cfg_q;

    // checks
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_after_req: assert property (acc && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_bovp_hidden: assert property ( // [RULE3]
        evt_i.boost_ovp && prot_q[7] && !stat_q[0] |=> !stat_q[0])
        else $error("inhibited boost overvoltage was reported");
    a_bovp_shown: assert property ( // [RULE3]
        evt_i.boost_ovp && !prot_q[7] |=> stat_q[0] && fault_o)
        else $error("boost overvoltage not reported");
    a_ocp_recover: assert property ( // [RULE4]
        evt_i.boost_ocp && !prot_q[6] |=> recovery_o)
        else $error("overcurrent recovery missing");
    a_ocp_inhibit: assert property ( // [RULE4]
        evt_i.boost_ocp && prot_q[6] && !evt_i.supply_ovp
        && !evt_i.supply_uv |=> !recovery_o)
        else $error("inhibited overcurrent entered recovery");
    a_ocp_status: assert property ( // [RULE4]
        evt_i.boost_ocp && prot_q[6] |=> stat_q[1] && fault_o)
        else $error("inhibited overcurrent not reported");
    a_uv_off: assert property ( // [RULE7]
        evt_i.supply_uv && prot_q[3:2] == 2'h0 && !stat_q[3]
        |=> !stat_q[3])
        else $error("undervolt seen with detection off");
    a_reserved_zero: assert property ( // [RULE18]
        rate_q[7:5] == 3'h0 && drive_q[7:6] == 2'h0)
        else $error("reserved bit stored");
    a_fallback_go: assert property ( // [RULE11]
        clk_state_q == bpc_pkg::BPC_CLK_EXT && ext_sel && absent
        |=> clk_state_q == bpc_pkg::BPC_CLK_FALLBACK ##1
            cfg_o.switching_khz == $past(fb_khz(clkcfg_q[2:0])))
        else $error("fallback not taken");
    a_ss_bound: assert property (ss_pct_q >= -3'sd3) // [RULE14]
        else $error("spread out of range");
    a_ss_off: assert property ( // [RULE14]
        !clkcfg_q[7] |=> ss_pct_q == 3'sd0)
        else $error("spread not zero while disabled");
endmodule : bpc_bank

// ==== shared/bpc_pkg.sv ====
// bpc_pkg: map, field layout, reset values and timing for the boost and
// protection configuration bank.
// assumes a single 50 MHz clock domain and a classic wishbone host.
package bpc_pkg;
    localparam int unsigned CLK_PERIOD_NS = 20;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_RATE = 8'h6e;
    localparam logic [7:0] IDX_PROT = 8'h6f;
    localparam logic [7:0] IDX_DRIVE = 8'h70;
    localparam logic [7:0] IDX_CLOCK = 8'h71;
    localparam logic [7:0] IDX_STAT = 8'h78;
    localparam logic [7:0] IDX_MASK = 8'h79;
    localparam logic [7:0] IDX_CLKST = 8'h7a;
    // field positions
    localparam int RATE_REF_BIT = 4;
    localparam int RATE_CODE_LSB = 0;
    localparam int PROT_BOVP_BIT = 7;
    localparam int PROT_BOCP_BIT = 6;
    localparam int PROT_SOVP_BIT = 5;
    localparam int PROT_SUV_BIT = 4;
    localparam int PROT_UV_LSB = 2;
    localparam int PROT_OV_LSB = 0;
    localparam int DRV_DELAY_BIT = 5;
    localparam int DRV_EXT_BIT = 4;
    localparam int DRV_IMAX_LSB = 1;
    localparam int DRV_GD_BIT = 0;
    localparam int CLK_SS_BIT = 7;
    localparam int CLK_IND_LSB = 5;
    localparam int CLK_RAMP_LSB = 3;
    localparam int CLK_FREQ_LSB = 0;
    // writable bits; the rest read as zero
    localparam logic [7:0] RATE_WMASK = 8'h1f;
    localparam logic [7:0] PROT_WMASK = 8'hff;
    localparam logic [7:0] DRV_WMASK = 8'h3f;
    localparam logic [7:0] CLK_WMASK = 8'hff;
    // reset values
    localparam logic [7:0] RATE_RST = 8'h00;
    localparam logic [7:0] PROT_RST = 8'h00;
    localparam logic [7:0] DRV_RST = 8'h00;
    localparam logic [7:0] CLK_RST = 8'h00;
    localparam logic [3:0] EVT_RST = 4'h0;
    // event bit positions in status and mask
    localparam int EVT_BOVP = 0;
    localparam int EVT_BOCP = 1;
    localparam int EVT_SOVP = 2;
    localparam int EVT_SUV = 3;
    // fallback when the external clock is gone for 1.52 periods
    localparam logic [23:0] ABSENT_NUM = 24'h000098;
    localparam logic [23:0] ABSENT_DEN = 24'h000064;
    localparam logic [5:0] RAMP_DELAY_PCT = 6'h23;
    localparam logic [3:0] IMAX_BASE_A = 4'h2;
    // spread spectrum: +-3 %, 1.875 kHz modulation
    localparam int SS_SPAN_PCT = 3;
    localparam int SS_MOD_PERIOD_NS = 533333;
    localparam int SS_MOD_CYCLES = SS_MOD_PERIOD_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        BPC_CLK_INT,
        BPC_CLK_EXT,
        BPC_CLK_FALLBACK
    } bpc_clk_state_t;

    typedef struct packed {
        logic supply_uv;
        logic supply_ovp;
        logic boost_ocp;
        logic boost_ovp;
    } bpc_evt_t;

    typedef struct packed {
        logic frame_rate_ref;
        logic [3:0] dimming_rate_code;
        logic [7:0] undervolt_dv;
        logic [7:0] overvolt_dv;
        logic [5:0] ramp_delay_pct;
        logic [3:0] current_limit_a;
        logic gate_drive_supply_select;
        logic [10:0] ramp_peak_x10;
        logic [11:0] switching_khz;
        logic signed [2:0] spread_pct;
        logic use_ext_clk;
    } bpc_cfg_t;
endpackage : bpc_pkg

// ==== test/bpc_bank_tb.sv ====
// bpc_bank_tb: self-checking bench for the boost and protection bank.
// assumes bpc_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/1ns
module bpc_bank_tb;
    localparam logic [7:0] RATE = bpc_pkg::IDX_RATE;
    localparam logic [7:0] PROT = bpc_pkg::IDX_PROT;
    localparam logic [7:0] DRV = bpc_pkg::IDX_DRIVE;
    localparam logic [7:0] CLKR = bpc_pkg::IDX_CLOCK;
    localparam logic [7:0] STAT = bpc_pkg::IDX_STAT;
    localparam int KHZ_INT [8] = '{100, 200, 303, 400, 629, 1100, 1100, 2200};
    localparam int UV_DV [4] = '{0, 30, 50, 80};
    localparam int OV_DV [4] = '{0, 70, 110, 225};
    logic clk;
    logic rst_n;
    logic wb_cyc_i;
    logic wb_stb_i;
    logic wb_we_i;
    logic [31:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    bpc_pkg::bpc_evt_t evt_i;
    logic sync_in;
    bpc_pkg::bpc_cfg_t cfg_o;
    logic fault_o;
    logic recovery_o;
    logic irq_o;
    logic [31:0] rd;
    logic rec;
    int n_errors = 0;
    int compares = 0;

    // short modulation period keeps the spread sweep within 48 cycles
    bpc_bank #(.SS_MOD_CYCLES(48)) dut (.clk(clk), .rst_n(rst_n),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .evt_i(evt_i),
        .sync_in(sync_in), .cfg_o(cfg_o), .fault_o(fault_o),
        .recovery_o(recovery_o), .irq_o(irq_o));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one classic cycle; entered and left just after a rising edge
    task automatic wb(input logic we, input logic [7:0] idx,
                      input logic [7:0] d);
        int i;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {22'h0, idx, 2'b00};
        wb_dat_i <= {24'h0, d};
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (wb_ack_o === 1'b1) break;
        end
        if (i == 20) chk("wb ack", 32'h1, 32'h0);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk);
    endtask : wb

    // cfg_o trails the register by a cycle, so let two edges pass
    task automatic settle;
        repeat (2) @(posedge clk);
    endtask : settle

    task automatic pulse(input logic [3:0] e);
        evt_i <= e;
        rec = 1'b0;
        @(posedge clk);
        evt_i <= 4'h0;
        repeat (3) begin
            @(posedge clk);
            if (recovery_o === 1'b1) rec = 1'b1;
        end
    endtask : pulse

    task automatic t_regs;
        int i;
        for (i = 0; i < 4; i++) begin
            wb(1'b0, RATE + 8'(i), 8'h00);
            chk("reset value", 32'h0, rd);
        end
        wb(1'b1, RATE, 8'hff);
        wb(1'b0, RATE, 8'h00);
        chk("rate readback", 32'h1f, rd);
        wb(1'b1, DRV, 8'hef);
        wb(1'b0, DRV, 8'h00);
        chk("drive readback", 32'h2f, rd);
        settle();
        chk("frame ref", 32'h1, cfg_o.frame_rate_ref);
        chk("rate code", 32'hf, cfg_o.dimming_rate_code);
        chk("ramp delay", 32'h23, cfg_o.ramp_delay_pct);
        chk("gate supply", 32'h1, cfg_o.gate_drive_supply_select);
        for (i = 0; i < 8; i++) begin
            wb(1'b1, DRV, 8'(i * 2));
            settle();
            chk("current limit", 32'(i + 2), cfg_o.current_limit_a);
        end
        chk("delay off", 32'h0, cfg_o.ramp_delay_pct);
        wb(1'b1, RATE, 8'h00);
        settle();
        chk("line ref", 32'h0, cfg_o.frame_rate_ref);
        // a write without lane 0 selected must not land
        wb_sel_i <= 4'he;
        wb(1'b1, RATE, 8'h0f);
        wb_sel_i <= 4'hf;
        wb(1'b0, RATE, 8'h00);
        chk("lane refused", 32'h0, rd);
        wb(1'b0, 8'h10, 8'h00);
        chk("unmapped read", 32'h0, rd);
    endtask : t_regs

    task automatic t_prot;
        int i;
        for (i = 0; i < 4; i++) begin
            wb(1'b1, PROT, 8'(i * 5));
            settle();
            chk("uv threshold", 32'(UV_DV[i]), cfg_o.undervolt_dv);
            chk("ov threshold", 32'(OV_DV[i]), cfg_o.overvolt_dv);
        end
    endtask : t_prot

    task automatic t_events;
        int k;
        int m;
        wb(1'b1, bpc_pkg::IDX_MASK, 8'h03);
        wb(1'b1, PROT, 8'h85);
        pulse(4'h1);
        chk("hidden fault", 32'h0, fault_o);
        wb(1'b0, STAT, 8'h00);
        chk("hidden status", 32'h0, rd);
        wb(1'b1, PROT, 8'h05);
        pulse(4'h1);
        chk("ovp fault", 32'h1, fault_o);
        chk("ovp irq", 32'h1, irq_o);
        chk("ovp no recovery", 32'h0, rec);
        wb(1'b1, STAT, 8'h01);
        chk("cleared irq", 32'h0, irq_o);
        chk("cleared fault", 32'h0, fault_o);
        // inhibit bits 6..4 pair with event bits 1..3
        for (k = 0; k < 3; k++) begin
            for (m = 0; m < 2; m++) begin
                wb(1'b1, PROT, 8'h05 | (m ? 8'(8'h40 >> k) : 8'h00));
                pulse(4'(4'h2 << k));
                chk("recovery", 32'(m == 0), rec);
                chk("fault pin", 32'h1, fault_o);
                chk("masked irq", 32'(k == 0), irq_o);
                wb(1'b1, STAT, 8'h0f);
            end
        end
        chk("status clear", 32'h0, fault_o);
        wb(1'b1, PROT, 8'h00);
        pulse(4'hc);
        chk("off fault", 32'h0, fault_o);
        chk("off recovery", 32'h0, rec);
    endtask : t_events

    task automatic t_clock;
        int i;
        int s;
        int hi;
        int lo;
        for (i = 0; i < 8; i++) begin
            wb(1'b1, CLKR, 8'(i));
            settle();
            chk("int rate", 32'(KHZ_INT[i]), cfg_o.switching_khz);
        end
        chk("ramp peak max", 32'd1300, cfg_o.ramp_peak_x10);
        chk("no spread", 32'h0, 32'(cfg_o.spread_pct));
        wb(1'b1, CLKR, 8'h78);
        settle();
        chk("ramp peak min", 32'd85, cfg_o.ramp_peak_x10);
        // inductor 10 with slope 01 is 23; swapped fields would give 28
        wb(1'b1, CLKR, 8'hcb);
        settle();
        chk("ramp peak mid", 32'd230, cfg_o.ramp_peak_x10);
        hi = -9;
        lo = 9;
        repeat (120) begin
            @(posedge clk);
            s = $signed(cfg_o.spread_pct);
            if (s > hi) hi = s;
            if (s < lo) lo = s;
        end
        chk("spread peak", 32'd3, 32'(hi));
        chk("spread low", 32'(-3), 32'(lo));
    endtask : t_clock

    task automatic t_fallback;
        wb(1'b1, CLKR, 8'h04);
        wb(1'b1, DRV, 8'h10);
        repeat (4) begin
            sync_in <= 1'b1;
            repeat (10) @(posedge clk);
            sync_in <= 1'b0;
            repeat (10) @(posedge clk);
        end
        chk("on external", 32'h0, cfg_o.switching_khz);
        // period 20, so absence shows after about 31 cycles
        repeat (40) @(posedge clk);
        chk("fallback rate", 32'd625, cfg_o.switching_khz);
        wb(1'b0, bpc_pkg::IDX_CLKST, 8'h00);
        chk("fallback flag", 32'h1, rd);
        wb(1'b1, DRV, 8'h00);
        settle();
        chk("back internal", 32'd629, cfg_o.switching_khz);
    endtask : t_fallback

    task automatic test_done;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done

    // the sequence needs well under 10000 cycles
    initial begin
        #400000;
        n_errors++;
        $display("mismatch watchdog expected done seen timeout");
        test_done();
    end

    initial begin
        rst_n = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 32'h0;
        wb_sel_i = 4'hf;
        wb_dat_i = 32'h0;
        evt_i = 4'h0;
        sync_in = 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_prot();
        t_events();
        t_clock();
        t_fallback();
        test_done();
    end
endmodule : bpc_bank_tb
